// ### logic/sdram_cmd_defs.svh
// Constants of the synchronous DRAM command interface.
// Included by the design file and the bench; definitions only.
`ifndef SDRAM_CMD_DEFS_SVH
`define SDRAM_CMD_DEFS_SVH
// Command codes {row strobe, column strobe, write enable}
`define CMD_MRS 3'h0
`define CMD_REF 3'h1
`define CMD_PRE 3'h2
`define CMD_ACT 3'h3
`define CMD_WR 3'h4
`define CMD_RD 3'h5
`define CMD_BST 3'h6
// Mode register fields
`define MR_BL 2:0
`define MR_BT 3
`define MR_CL 6:4
`define MR_WBM 9
`define MODE_RST 11'h000
`define BL_FULL 3'h7
`define CL3 3'h3
// Address bit that selects all banks or auto-precharge
`define AP_BIT 10
`endif

// ### logic/sdram_pkg.sv
// Types shared by the command interface design.
// Assumes the defines header sits beside it.
package sdram_pkg;
  typedef enum logic [1:0] {PWR_RUN, PWR_DOWN, PWR_SUSPEND, PWR_SELF} pwr_t;
endpackage

// ### logic/sdram_cmd_if.sv
// Command interface and storage of a two-bank 16-bit synchronous DRAM.
// Assumes the controller runs on I_CLK, so pins need no synchroniser.
// Summary of operation
// - Row on all address lines, column low eight
// - Bank select picks bank for row/column
// - Chip select high ignores commands, burst continues
// - Strobe levels sampled at rising edge
// - Read byte mask floats output two later
// - Write byte mask blocks write same cycle
// - Clock enable low enters low power
// - Mode undefined until first programmed
// - All strobes low loads mode register
// - Column access; write enable picks direction
// - Column commands accepted every cycle
// - Read burst decode, length from mode
// - Sequential burst wraps within low bits
// - Interleave burst below full page XORs beat index into low column bits
// - Address bit ten auto-precharges after burst
`timescale 1ns/1ns
`include "sdram_cmd_defs.svh"

module sdram_wbuf #(
  parameter int W = 38,
  parameter int DEPTH = 8
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [W-1:0] i_data,
  output logic o_valid,
  input wire logic i_ready,
  output logic [W-1:0] o_data
);
  localparam int PW = $clog2(DEPTH);
  logic [W-1:0] buf_mem [DEPTH];
  logic [PW-1:0] wp_reg, wp_next, rp_reg, rp_next;
  logic [PW:0] cnt_reg, cnt_next;
  logic rdy_reg, rdy_next, push, pop;

  assign o_ready = rdy_reg;
  assign o_valid = cnt_reg != '0;
  assign o_data = buf_mem[rp_reg];

  always_comb begin
    push = i_valid && rdy_reg;
    pop = o_valid && i_ready;
    wp_next = push ? wp_reg + 1'b1 : wp_reg;
    rp_next = pop ? rp_reg + 1'b1 : rp_reg;
    cnt_next = cnt_reg + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
    rdy_next = cnt_next != (PW+1)'(DEPTH);
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
      rdy_reg <= 1'b1;
    end else begin
      wp_reg <= wp_next;
      rp_reg <= rp_next;
      cnt_reg <= cnt_next;
      rdy_reg <= rdy_next;
    end
  end

  always_ff @(posedge i_clk) begin
    if (push) begin
      buf_mem[wp_reg] <= i_data;
    end
  end
endmodule

module sdram_cmd_if #(
  parameter int AW = 11,
  parameter int CW = 8,
  parameter int DW = 16
) (
  input wire logic I_CLK,
  input wire logic I_RSTN,
  input wire logic I_CKE,
  input wire logic I_CS_N,
  input wire logic I_RAS_N,
  input wire logic I_CAS_N,
  input wire logic I_WE_N,
  input wire logic I_BA,
  input wire logic [AW-1:0] I_ADDR,
  input wire logic I_UPPER_BYTE_MASK,
  input wire logic I_LOWER_BYTE_MASK,
  input wire logic [DW-1:0] I_DQ,
  output logic [DW-1:0] O_DQ,
  output logic [1:0] O_DQ_OE_N,
  output logic O_MODE_VALID,
  output logic [1:0] O_BANK_OPEN,
  output logic [1:0] O_PWR_STATE,
  output logic O_WBUF_READY
);
  localparam int MW = 1 + AW + CW;
  localparam int QW = MW + DW + 2;

  logic [DW-1:0] mem [2**MW];
  sdram_pkg::pwr_t pwr_reg, pwr_next;
  logic [AW-1:0] mode_reg, mode_next, row_reg [2], row_next [2];
  logic mval_reg, mval_next, bst_act_reg, bst_act_next;
  logic bst_wr_reg, bst_wr_next, bst_ap_reg, bst_ap_next;
  logic bst_bank_reg, bst_bank_next;
  logic [1:0] open_reg, open_next, dqm_d0_reg, dqm_d0_next;
  logic [1:0] dqm_d1_reg, dqm_d1_next, oe_n_reg, oe_n_next;
  logic [CW-1:0] bst_start_reg, bst_start_next, bst_idx_reg, bst_idx_next;
  logic [2:0] rd_v_reg, rd_v_next;
  logic [2:0][DW-1:0] rd_d_reg, rd_d_next;
  logic [DW-1:0] dq_reg, dq_next;
  logic [2:0] cmd, bl;
  logic en, sel, acc_v, acc_wr, acc_bank, cl3, last, vsel;
  logic [CW-1:0] acc_col, lmask;
  logic [1:0] dqm;
  logic q_in_v, q_rdy, q_out_v;
  logic [QW-1:0] q_out;

  function automatic logic [CW-1:0] bl_mask(input logic [2:0] b);
    case (b)
      3'h0: bl_mask = '0;
      3'h1: bl_mask = CW'(8'h01);
      3'h2: bl_mask = CW'(8'h03);
      3'h3: bl_mask = CW'(8'h07);
      default: bl_mask = '1;
    endcase
  endfunction

  function automatic logic [CW-1:0] burst_col(input logic [CW-1:0] s,
      input logic [CW-1:0] i, input logic [2:0] b, input logic t);
    logic [CW-1:0] m;
    m = bl_mask(b);
    if (t && b != `BL_FULL) begin
      burst_col = (s & ~m) | ((s ^ i) & m);
    end else begin
      burst_col = (s & ~m) | ((s + i) & m);
    end
  endfunction

  function automatic logic [MW-1:0] mem_idx(input logic b,
      input logic [AW-1:0] r, input logic [CW-1:0] c);
    mem_idx = {b, r, c};
  endfunction

  assign O_DQ = dq_reg;
  assign O_DQ_OE_N = oe_n_reg;
  assign O_MODE_VALID = mval_reg;
  assign O_BANK_OPEN = open_reg;
  assign O_PWR_STATE = pwr_reg;

  always_comb begin
    en = pwr_reg == sdram_pkg::PWR_RUN;
    sel = !I_CS_N && en;
    cmd = {I_RAS_N, I_CAS_N, I_WE_N};
    dqm = {I_UPPER_BYTE_MASK, I_LOWER_BYTE_MASK};
    cl3 = mode_reg[`MR_CL] == `CL3;
    mode_next = mode_reg;
    mval_next = mval_reg;
    open_next = open_reg;
    row_next = row_reg;
    bst_act_next = bst_act_reg;
    bst_wr_next = bst_wr_reg;
    bst_ap_next = bst_ap_reg;
    bst_bank_next = bst_bank_reg;
    bst_start_next = bst_start_reg;
    bst_idx_next = bst_idx_reg;
    bl = (bst_wr_reg && mode_reg[`MR_WBM]) ? 3'h0 : mode_reg[`MR_BL];
    lmask = bl_mask(bl);
    last = bst_idx_reg == lmask && bl != `BL_FULL;
    acc_v = en && bst_act_reg;
    acc_wr = bst_wr_reg;
    acc_bank = bst_bank_reg;
    acc_col = burst_col(bst_start_reg, bst_idx_reg, bl, mode_reg[`MR_BT]);
    if (acc_v) begin
      if (last) begin
        bst_act_next = 1'b0;
        if (bst_ap_reg) begin
          open_next[bst_bank_reg] = 1'b0;
        end
      end else begin
        bst_idx_next = bst_idx_reg + 1'b1;
      end
    end
    if (sel) begin
      case (cmd)
        `CMD_MRS: begin
          mode_next = I_ADDR;
          mval_next = 1'b1;
        end
        `CMD_PRE: begin
          if (I_ADDR[`AP_BIT]) begin
            open_next = 2'h0;
            bst_act_next = 1'b0;
          end else begin
            open_next[I_BA] = 1'b0;
            if (bst_bank_reg == I_BA) begin
              bst_act_next = 1'b0;
            end
          end
        end
        `CMD_ACT: begin
          open_next[I_BA] = 1'b1;
          row_next[I_BA] = I_ADDR;
        end
        `CMD_RD, `CMD_WR: begin
          if (open_reg[I_BA]) begin
            acc_v = 1'b1;
            acc_wr = !I_WE_N;
            acc_bank = I_BA;
            acc_col = I_ADDR[CW-1:0];
            bl = (acc_wr && mode_reg[`MR_WBM]) ? 3'h0 : mode_reg[`MR_BL];
            bst_wr_next = acc_wr;
            bst_ap_next = I_ADDR[`AP_BIT];
            bst_bank_next = I_BA;
            bst_start_next = I_ADDR[CW-1:0];
            bst_idx_next = CW'(8'h01);
            bst_act_next = bl_mask(bl) != '0;
            if (bl_mask(bl) == '0 && I_ADDR[`AP_BIT]) begin
              open_next[I_BA] = 1'b0;
            end
          end
        end
        `CMD_BST: bst_act_next = 1'b0;
        default: ;
      endcase
    end
    q_in_v = acc_v && acc_wr && dqm != 2'h3;
    rd_v_next = rd_v_reg;
    rd_d_next = rd_d_reg;
    dqm_d0_next = dqm_d0_reg;
    dqm_d1_next = dqm_d1_reg;
    dq_next = dq_reg;
    oe_n_next = oe_n_reg;
    vsel = cl3 ? rd_v_reg[2] : rd_v_reg[1];
    if (en) begin
      rd_v_next = {rd_v_reg[1:0], acc_v && !acc_wr};
      rd_d_next = {rd_d_reg[1:0],
        mem[mem_idx(acc_bank, row_reg[acc_bank], acc_col)]};
      dqm_d0_next = dqm;
      dqm_d1_next = dqm_d0_reg;
      dq_next = cl3 ? rd_d_reg[2] : rd_d_reg[1];
      oe_n_next = {2{!vsel}} | dqm_d1_reg;
    end
    case (pwr_reg)
      sdram_pkg::PWR_SELF: begin
        pwr_next = I_CKE ? sdram_pkg::PWR_RUN : sdram_pkg::PWR_SELF;
      end
      default: begin
        if (I_CKE) begin
          pwr_next = sdram_pkg::PWR_RUN;
        end else if (sel && cmd == `CMD_REF) begin
          pwr_next = sdram_pkg::PWR_SELF;
        end else if (bst_act_reg || rd_v_reg != 3'h0) begin
          pwr_next = sdram_pkg::PWR_SUSPEND;
        end else begin
          pwr_next = sdram_pkg::PWR_DOWN;
        end
      end
    endcase
  end

  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      pwr_reg <= sdram_pkg::PWR_RUN;
      mode_reg <= `MODE_RST;
      mval_reg <= 1'b0;
      open_reg <= 2'h0;
      row_reg <= '{default: '0};
      bst_act_reg <= 1'b0;
      bst_wr_reg <= 1'b0;
      bst_ap_reg <= 1'b0;
      bst_bank_reg <= 1'b0;
      bst_start_reg <= '0;
      bst_idx_reg <= '0;
      rd_v_reg <= 3'h0;
      rd_d_reg <= '0;
      dqm_d0_reg <= 2'h3;
      dqm_d1_reg <= 2'h3;
      dq_reg <= '0;
      oe_n_reg <= 2'h3;
    end else begin
      pwr_reg <= pwr_next;
      mode_reg <= mode_next;
      mval_reg <= mval_next;
      open_reg <= open_next;
      row_reg <= row_next;
      bst_act_reg <= bst_act_next;
      bst_wr_reg <= bst_wr_next;
      bst_ap_reg <= bst_ap_next;
      bst_bank_reg <= bst_bank_next;
      bst_start_reg <= bst_start_next;
      bst_idx_reg <= bst_idx_next;
      rd_v_reg <= rd_v_next;
      rd_d_reg <= rd_d_next;
      dqm_d0_reg <= dqm_d0_next;
      dqm_d1_reg <= dqm_d1_next;
      dq_reg <= dq_next;
      oe_n_reg <= oe_n_next;
    end
  end

  // Queued writes drain while internal clocking runs
  sdram_wbuf #(.W(QW), .DEPTH(8)) u_wbuf (
    .i_clk(I_CLK),
    .i_rstn(I_RSTN),
    .i_valid(q_in_v),
    .o_ready(q_rdy),
    .i_data({mem_idx(acc_bank, row_reg[acc_bank], acc_col), I_DQ, ~dqm}),
    .o_valid(q_out_v),
    .i_ready(en),
    .o_data(q_out)
  );
  assign O_WBUF_READY = q_rdy;

  always_ff @(posedge I_CLK) begin
    if (q_out_v && en) begin
      if (q_out[0]) begin
        mem[q_out[QW-1 -: MW]][7:0] <= q_out[9:2];
      end
      if (q_out[1]) begin
        mem[q_out[QW-1 -: MW]][15:8] <= q_out[17:10];
      end
    end
  end

  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (!I_RSTN);

  property p_mrs;
    sel && cmd == `CMD_MRS |=> mode_reg == $past(I_ADDR) && O_MODE_VALID;
  endproperty
  a_mrs: assert property (p_mrs) else $error("mode not loaded");

  property p_cs;
    en && I_CS_N && !bst_act_reg |=> $stable(open_reg) && $stable(mode_reg);
  endproperty
  a_cs: assert property (p_cs) else $error("deselect changed state");

  property p_act;
    sel && cmd == `CMD_ACT |=> open_reg[$past(I_BA)]
      && row_reg[$past(I_BA)] == $past(I_ADDR);
  endproperty
  a_act: assert property (p_act) else $error("activate lost");

  property p_rdmask;
    en && I_UPPER_BYTE_MASK ##1 en ##1 en |=> O_DQ_OE_N[1];
  endproperty
  a_rdmask: assert property (p_rdmask) else $error("mask ignored");

  property p_wrmask;
    acc_v && acc_wr && dqm == 2'h3 |-> !q_in_v;
  endproperty
  a_wrmask: assert property (p_wrmask) else $error("masked write");

  property p_cke;
    en && !I_CKE |=> O_PWR_STATE != 2'(sdram_pkg::PWR_RUN);
  endproperty
  a_cke: assert property (p_cke) else $error("no low power");

  property p_cl3;
    en && cl3 && rd_v_reg[2] && !dqm_d1_reg[0] |=> !O_DQ_OE_N[0];
  endproperty
  a_cl3: assert property (p_cl3) else $error("read not driven");

  property p_ap;
    acc_v && bst_act_reg && last && bst_ap_reg && !sel
      |=> !open_reg[$past(bst_bank_reg)];
  endproperty
  a_ap: assert property (p_ap) else $error("no auto-precharge");

  property p_seq;
    acc_v && bst_act_reg && !mode_reg[`MR_BT] && !sel
      |-> (acc_col & ~lmask) == (bst_start_reg & ~lmask);
  endproperty
  a_seq: assert property (p_seq) else $error("burst carried");

  property p_int;
    acc_v && bst_act_reg && mode_reg[`MR_BT] && bl != `BL_FULL && !sel
      |-> (acc_col ^ bst_start_reg) == (bst_idx_reg & lmask);
  endproperty
  a_int: assert property (p_int) else $error("bad interleave");

  property p_b2b;
    sel && (cmd == `CMD_RD || cmd == `CMD_WR) && open_reg[I_BA] |-> acc_v;
  endproperty
  a_b2b: assert property (p_b2b) else $error("access dropped");

  c_rd: cover property (sel && cmd == `CMD_RD ##[1:4] !O_DQ_OE_N[0]);
  c_wr: cover property (q_in_v && bst_act_reg ##1 q_in_v);
  c_self: cover property (pwr_reg == sdram_pkg::PWR_SELF);
  c_susp: cover property (pwr_reg == sdram_pkg::PWR_SUSPEND);
endmodule

// ### verif/sdram_ctl_model.sv
// Behavioural memory controller that drives the command pins.
// Assumes its tasks are called at a falling edge of i_clk.
`timescale 1ns/1ns
`include "sdram_cmd_defs.svh"

module sdram_ctl_model #(
  parameter int T_PAUSE = 10000,
  parameter int T_GAP = 3
) (
  input wire logic i_clk,
  output logic o_cke,
  output logic o_cs_n,
  output logic o_ras_n,
  output logic o_cas_n,
  output logic o_we_n,
  output logic o_ba,
  output logic [10:0] o_addr,
  output logic o_upper_byte_mask,
  output logic o_lower_byte_mask,
  output logic [15:0] o_dq
);
  localparam logic [2:0] NOP_CMD = 3'h7;

  initial begin
    o_cke = 1'b1;
    o_cs_n = 1'b1;
    {o_ras_n, o_cas_n, o_we_n} = NOP_CMD;
    o_ba = 1'b0;
    o_addr = 11'h000;
    o_upper_byte_mask = 1'b1;
    o_lower_byte_mask = 1'b1;
    o_dq = 16'h0000;
  end

  // Idle cycles; released data lines toggle every cycle
  task automatic no_operation_cmd(input int n);
    repeat (n) begin
      o_cs_n = 1'b0;
      {o_ras_n, o_cas_n, o_we_n} = NOP_CMD;
      o_dq = ~o_dq;
      @(negedge i_clk);
    end
  endtask

  task automatic issue(input logic [2:0] cmd, input logic ba,
      input logic [10:0] addr, input logic [15:0] dq,
      input logic [1:0] m, input logic cs_n, input logic cke);
    o_cke = cke;
    o_cs_n = cs_n;
    {o_ras_n, o_cas_n, o_we_n} = cmd;
    o_ba = ba;
    o_addr = addr;
    {o_upper_byte_mask, o_lower_byte_mask} = m;
    o_dq = dq;
    @(negedge i_clk);
  endtask

  // Next word of a write burst
  task automatic beat(input logic [15:0] dq);
    issue(NOP_CMD, o_ba, o_addr, dq, 2'b00, 1'b0, o_cke);
  endtask

  // Close all banks, then program the mode
  task automatic prog(input logic [10:0] mode);
    issue(`CMD_PRE, 1'b0, 11'h400, 16'h0000, 2'b11, 1'b0, 1'b1);
    no_operation_cmd(T_GAP);
    issue(`CMD_MRS, 1'b0, mode, 16'h0000, 2'b11, 1'b0, 1'b1);
    no_operation_cmd(T_GAP);
  endtask

  task automatic init(input logic [10:0] mode);
    no_operation_cmd(T_PAUSE);
    prog(mode);
    repeat (8) begin
      issue(`CMD_REF, 1'b0, 11'h000, 16'h0000, 2'b11, 1'b0, 1'b1);
      no_operation_cmd(T_GAP);
    end
  endtask

  task automatic act(input logic ba, input logic [10:0] row);
    issue(`CMD_ACT, ba, row, 16'h0000, 2'b00, 1'b0, 1'b1);
    no_operation_cmd(T_GAP);
  endtask
endmodule

// ### verif/tb_top.sv
// Self-checking bench of the synchronous DRAM command interface.
// Assumes the design files and the controller model are compiled first.
`timescale 1ns/1ns
`include "sdram_cmd_defs.svh"

module tb_top;
  localparam logic [2:0] NOPC = 3'h7;
  logic clk;
  logic rstn;
  logic cke, cs_n, ras_n, cas_n, we_n, ba, upper_byte_mask, lower_byte_mask;
  logic [10:0] addr;
  logic [15:0] dq_in;
  logic [15:0] dq_out;
  logic [1:0] oe_n;
  logic mode_ok;
  logic [1:0] bank_open;
  logic [1:0] pwr;
  logic wbuf_rdy;
  int err_total;
  int samples_checked;
  logic [15:0] exp_q[$];

  sdram_ctl_model ctl (.i_clk(clk), .o_cke(cke), .o_cs_n(cs_n),
    .o_ras_n(ras_n), .o_cas_n(cas_n), .o_we_n(we_n), .o_ba(ba),
    .o_addr(addr), .o_upper_byte_mask(upper_byte_mask), .o_lower_byte_mask(lower_byte_mask), .o_dq(dq_in));

  sdram_cmd_if uut (.I_CLK(clk), .I_RSTN(rstn), .I_CKE(cke),
    .I_CS_N(cs_n), .I_RAS_N(ras_n), .I_CAS_N(cas_n), .I_WE_N(we_n),
    .I_BA(ba), .I_ADDR(addr), .I_UPPER_BYTE_MASK(upper_byte_mask), .I_LOWER_BYTE_MASK(lower_byte_mask),
    .I_DQ(dq_in), .O_DQ(dq_out), .O_DQ_OE_N(oe_n),
    .O_MODE_VALID(mode_ok), .O_BANK_OPEN(bank_open),
    .O_PWR_STATE(pwr), .O_WBUF_READY(wbuf_rdy));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic report_and_stop();
    if (err_total == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Read, then compare each queued word and the enables
  task automatic rd(input logic b, input logic [10:0] a,
      input logic [1:0] m, input int cl);
    logic [15:0] keep;
    keep = {{8{~m[1]}}, {8{~m[0]}}};
    ctl.issue(`CMD_RD, b, a, 16'h0000, m, 1'b0, 1'b1);
    ctl.no_operation_cmd(cl);
    while (exp_q.size() > 0) begin
      chk(dq_out & keep, exp_q.pop_front() & keep);
      chk({14'h0000, oe_n}, {14'h0000, m});
      ctl.no_operation_cmd(1);
    end
    chk({14'h0000, oe_n}, 16'h0003);
  endtask

  // Tests take about 10200 cycles
  initial begin
    #(30000 * 20);
    err_total++;
    report_and_stop();
  end

  initial begin
    err_total = 0;
    samples_checked = 0;
    rstn = 1'b0;
    repeat (6) @(posedge clk);
    @(negedge clk);
    chk({14'h0000, oe_n}, 16'h0003);
    chk({15'h0000, mode_ok}, 16'h0000);
    chk({14'h0000, bank_open}, 16'h0000);
    chk({15'h0000, wbuf_rdy}, 16'h0001);
    rstn = 1'b1;
    ctl.init(11'h000);
    chk({15'h0000, mode_ok}, 16'h0001);
    ctl.act(1'b0, 11'h7FF);
    ctl.act(1'b1, 11'h2AA);
    chk({14'h0000, bank_open}, 16'h0003);
    ctl.issue(`CMD_WR, 1'b0, 11'h005, 16'h1234, 2'b00, 1'b0, 1'b1);
    ctl.issue(`CMD_WR, 1'b1, 11'h005, 16'h5678, 2'b00, 1'b0, 1'b1);
    ctl.issue(`CMD_WR, 1'b0, 11'h006, 16'h1111, 2'b00, 1'b0, 1'b1);
    ctl.issue(`CMD_WR, 1'b0, 11'h006, 16'hABCD, 2'b10, 1'b0, 1'b1);
    ctl.issue(`CMD_WR, 1'b0, 11'h005, 16'hDEAD, 2'b00, 1'b1, 1'b1);
    ctl.no_operation_cmd(2);
    exp_q = '{16'h1234};
    rd(1'b0, 11'h005, 2'b00, 2);
    exp_q = '{16'h5678};
    rd(1'b1, 11'h005, 2'b00, 2);
    exp_q = '{16'h11CD};
    rd(1'b0, 11'h006, 2'b00, 2);
    exp_q = '{16'h1234};
    rd(1'b0, 11'h005, 2'b10, 2);
    ctl.prog(11'h000);
    chk({14'h0000, bank_open}, 16'h0000);
    ctl.issue(NOPC, 1'b0, 11'h000, 16'h0000, 2'b00, 1'b0, 1'b0);
    chk({14'h0000, pwr}, 16'h0001);
    ctl.issue(NOPC, 1'b0, 11'h000, 16'h0000, 2'b00, 1'b0, 1'b1);
    chk({14'h0000, pwr}, 16'h0000);
    ctl.issue(`CMD_REF, 1'b0, 11'h000, 16'h0000, 2'b00, 1'b0, 1'b0);
    ctl.no_operation_cmd(1);
    chk({14'h0000, pwr}, 16'h0003);
    ctl.issue(NOPC, 1'b0, 11'h000, 16'h0000, 2'b00, 1'b0, 1'b1);
    chk({14'h0000, pwr}, 16'h0000);
    ctl.prog(11'h002);
    ctl.act(1'b0, 11'h7FF);
    ctl.issue(`CMD_WR, 1'b0, 11'h006, 16'hA000, 2'b00, 1'b0, 1'b1);
    for (int i = 1; i < 4; i++) begin
      ctl.beat({14'h2800, 2'(i)});
    end
    ctl.no_operation_cmd(2);
    exp_q = '{16'hA002, 16'hA003, 16'hA000, 16'hA001};
    rd(1'b0, 11'h004, 2'b00, 2);
    ctl.prog(11'h03A);
    ctl.act(1'b0, 11'h7FF);
    exp_q = '{16'hA003, 16'hA002, 16'hA001, 16'hA000};
    rd(1'b0, 11'h405, 2'b00, 3);
    ctl.no_operation_cmd(2);
    chk({14'h0000, bank_open}, 16'h0000);
    // Single-beat writes with every mask pattern, back to back
    ctl.prog(11'h202);
    ctl.act(1'b0, 11'h7FF);
    for (int k = 0; k < 4; k++) begin
      ctl.issue(`CMD_WR, 1'b0, 11'(4 + k),
        16'(16'hC0D0 + 16'h0101 * k), 2'(k), 1'b0, 1'b1);
    end
    // A stray beat must not land while single-beat writes are set
    ctl.beat(16'hFFFF);
    ctl.no_operation_cmd(2);
    exp_q = '{16'hC0D0, 16'hC103, 16'hA0D2, 16'hA001};
    rd(1'b0, 11'h004, 2'b00, 2);
    // Clock enable low during a burst suspends it
    ctl.issue(`CMD_RD, 1'b0, 11'h004, 16'h0000,
      2'b00, 1'b0, 1'b1);
    for (int k = 0; k < 2; k++) begin
      ctl.issue(NOPC, 1'b0, 11'h000, 16'h0000, 2'b00, 1'b0, k[0]);
      chk({14'h0000, pwr}, 16'(2 - 2 * k));
    end
    ctl.no_operation_cmd(8);
    chk({14'h0000, oe_n}, 16'h0003);
    report_and_stop();
  end
endmodule
